// *** dmars_pkg.sv ***
// dmars_pkg: constants, register map and source decoding for the dma request selector
// assumes a 32-bit classic wishbone register bus with byte addresses
package dmars_pkg;

    localparam int N_CH   = 4;
    localparam int N_TA   = 5;
    localparam int N_TB   = 6;
    localparam int N_UART = 3;
    localparam int N_IIO  = 12;

    // register byte offsets
    localparam logic [7:0] PRI_BASE_OFS = 8'h00; // primary_source_select_reg, channel i at +4i
    localparam logic [7:0] SEC_BASE_OFS = 8'h10; // secondary_source_select_reg, channel i at +4i
    localparam logic [7:0] STATUS_OFS   = 8'h20; // request seen flags, write one to clear

    // field positions and reset values
    localparam int         CODE_LSB     = 0;
    localparam int         CODE_MSB     = 4;
    localparam int         SW_TRIG_BIT  = 5;
    localparam logic [4:0] CODE_RST     = 5'h00;
    localparam logic [3:0] STATUS_RST   = 4'h0;

    // primary code points
    localparam logic [4:0] CODE_SECONDARY = 5'h00;
    localparam logic [4:0] CODE_PIN_FALL  = 5'h01;
    localparam logic [4:0] CODE_PIN_BOTH  = 5'h02;
    localparam logic [4:0] CODE_TA_FIRST  = 5'h03;
    localparam logic [4:0] CODE_TA_LAST   = 5'h07;
    localparam logic [4:0] CODE_TB_FIRST  = 5'h08;
    localparam logic [4:0] CODE_TB_LAST   = 5'h0D;
    localparam logic [4:0] CODE_UART_FIRST = 5'h0E;
    localparam logic [4:0] CODE_UART_LAST = 5'h13;
    localparam logic [4:0] CODE_ADC       = 5'h18;
    localparam logic [4:0] CODE_IIO_FIRST = 5'h19;
    localparam logic [4:0] IIO_WRAP       = 5'h0C;
    localparam logic [4:0] IIO_BASE [N_CH] = '{5'h00, 5'h07, 5'h02, 5'h09};

    typedef enum {CLS_SECONDARY, CLS_PIN_FALL, CLS_PIN_BOTH, CLS_TIMER_A, CLS_TIMER_B,
                  CLS_UART, CLS_ADC, CLS_IIO, CLS_NONE} dmars_class_t;

    // sort a primary code into its source class
    function automatic dmars_class_t dmars_class(input logic [4:0] code);
        if (code == CODE_SECONDARY) return CLS_SECONDARY;
        else if (code == CODE_PIN_FALL) return CLS_PIN_FALL;
        else if (code == CODE_PIN_BOTH) return CLS_PIN_BOTH;
        else if (code <= CODE_TA_LAST) return CLS_TIMER_A;
        else if (code <= CODE_TB_LAST) return CLS_TIMER_B;
        else if (code <= CODE_UART_LAST) return CLS_UART;
        else if (code == CODE_ADC) return CLS_ADC;
        else if (code >= CODE_IIO_FIRST) return CLS_IIO;
        else return CLS_NONE;
    endfunction

endpackage

// *** dmars_sel_if.sv ***
// dmars_sel_if: carries one channel's codes and the shared request sources to its selector
// assumes the top drives every source as a one-cycle or level request, synchronous to clk
`timescale 1ns/1ps
interface dmars_sel_if;
    logic [4:0]  pri_code;
    logic [4:0]  sec_code;
    logic        pin_fall;
    logic        pin_both;
    logic [4:0]  tima;
    logic [5:0]  timb;
    logic [2:0]  utx;
    logic [2:0]  urx;
    logic        adc;
    logic [11:0] iio;
    logic        sec_hw;
    logic        hw_req;

    modport top (output pri_code, sec_code, pin_fall, pin_both, tima, timb, utx, urx,
                 output adc, iio, sec_hw, input hw_req);
    modport sel (input pri_code, sec_code, pin_fall, pin_both, tima, timb, utx, urx,
                 input adc, iio, sec_hw, output hw_req);
endinterface

// *** dmars_chan_sel.sv ***
// dmars_chan_sel: combinational hardware request selector for one dma channel
// assumes the parent registers the result before it leaves the block
`timescale 1ns/1ps
module dmars_chan_sel
    import dmars_pkg::*;
#(
    parameter int CH = 0
) (
    dmars_sel_if.sel sif
);

    logic [4:0] off;
    logic [4:0] iio_sum;
    logic [4:0] iio_idx;

    // offset of the code inside its class and the rotated iio index
    always_comb begin
        off     = 5'h00;
        iio_sum = IIO_BASE[CH] + (sif.pri_code - CODE_IIO_FIRST);
        iio_idx = (iio_sum >= IIO_WRAP) ? iio_sum - IIO_WRAP : iio_sum;
        case (dmars_class(sif.pri_code))
            CLS_TIMER_A: off = sif.pri_code - CODE_TA_FIRST;
            CLS_TIMER_B: off = sif.pri_code - CODE_TB_FIRST;
            CLS_UART:    off = sif.pri_code - CODE_UART_FIRST;
            default:     off = 5'h00;
        endcase
    end

    // pick the request line named by the primary code
    always_comb begin
        case (dmars_class(sif.pri_code))
            CLS_SECONDARY: sif.hw_req = (sif.sec_code != CODE_SECONDARY) & sif.sec_hw;
            CLS_PIN_FALL:  sif.hw_req = sif.pin_fall;
            CLS_PIN_BOTH:  sif.hw_req = sif.pin_both;
            CLS_TIMER_A:   sif.hw_req = sif.tima[off[2:0]];
            CLS_TIMER_B:   sif.hw_req = sif.timb[off[2:0]];
            CLS_UART:      sif.hw_req = off[0] ? sif.urx[off[2:1]] : sif.utx[off[2:1]];
            CLS_ADC:       sif.hw_req = sif.adc;
            CLS_IIO:       sif.hw_req = sif.iio[iio_idx[3:0]];
            default:       sif.hw_req = 1'b0;
        endcase
    end

endmodule // dmars_chan_sel

// *** dmars_top.sv ***
// dmars_top: dma request source selection for four channels with a wishbone register file
// assumes synchronous peripheral request inputs and a classic wishbone master on clk
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// - writing the trigger bit in a secondary register requests a transfer on that channel
// - each channel takes hardware requests from the source its select codes name
// - no interrupt enable or interrupt control setting gates a transfer request
// - transfers never set or clear any peripheral pending interrupt flag
// - primary code zero hands source choice to the secondary register
// - codes 1 and 2 pick falling or both edges of that channel's pin
// - codes 3 to 7 pick timer A 0 to 4 requests
// - codes 8 to 13 pick timer B 0 to 5 requests
// - code 24 picks the converter 0 conversion request
// - codes 25 to 31 pick rotated intelligent io requests per channel
// - pin edge requests ignore the pin interrupt polarity and level settings
module dmars_top
    import dmars_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_irq_pin_0,
    input  wire logic        ext_irq_pin_1,
    input  wire logic        ext_irq_pin_2,
    input  wire logic        ext_irq_pin_3,
    input  wire logic [4:0]  timer_a_irq,
    input  wire logic [5:0]  timer_b_irq,
    input  wire logic [2:0]  uart_tx_irq,
    input  wire logic [2:0]  uart_rx_irq,
    input  wire logic [2:0]  uart_ack_irq,
    input  wire logic [2:0]  uart_ack_mode,
    input  wire logic        analog_converter_0_irq,
    input  wire logic [11:0] iio_irq,
    input  wire logic [3:0]  sec_src_irq,
    output logic      [3:0]  dma_req
);

    logic [4:0]  pri_code_reg [N_CH];
    logic [4:0]  sec_code_reg [N_CH];
    logic [3:0]  status_reg;
    logic [3:0]  pin_prev_reg;
    logic        pin_live_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [3:0]  dma_req_reg;
    logic [3:0]  pins;
    logic [3:0]  pin_fall;
    logic [3:0]  pin_both;
    logic [2:0]  urx_sel;
    logic [3:0]  hw_req;
    logic [3:0]  sw_trig;
    logic [3:0]  pri_wr;
    logic [3:0]  sec_wr;
    logic        req_phase;
    logic        wr_fire;
    logic [31:0] rdata_next;

    // word hit on a four-entry register group starting at base
    function automatic logic [3:0] group_hit(input logic [7:0] adr, input logic [7:0] base);
        logic [7:0] rel;
        rel = adr - base;
        group_hit = 4'h0;
        if (rel[7:4] == 4'h0 && rel[1:0] == 2'b00) begin
            group_hit[rel[3:2]] = 1'b1;
        end
    endfunction

    // bus phases: data goes out with ack, a write lands on the edge where ack is seen
    assign req_phase = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_fire   = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
    assign pri_wr    = wr_fire ? group_hit(wb_adr_i, PRI_BASE_OFS) : 4'h0;
    assign sec_wr    = wr_fire ? group_hit(wb_adr_i, SEC_BASE_OFS) : 4'h0;
    assign sw_trig   = wb_dat_i[SW_TRIG_BIT] ? sec_wr : 4'h0;

    // pin edges come straight off the pins, no polarity or level setting enters here
    assign pins     = {ext_irq_pin_3, ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};
    assign pin_fall = pin_live_reg ? (pin_prev_reg & ~pins) : 4'h0;
    assign pin_both = pin_live_reg ? (pin_prev_reg ^ pins) : 4'h0;

    // receive line of each serial port, swapped for acknowledge when that mode is set
    assign urx_sel = (uart_rx_irq & ~uart_ack_mode) | (uart_ack_irq & uart_ack_mode);

    // one selector per channel, sharing the peripheral sources, each with its own pin edges and secondary line
    generate
        for (genvar ch = 0; ch < N_CH; ch++) begin : g_chan
            dmars_sel_if sif ();
            assign sif.pri_code = pri_code_reg[ch];
            assign sif.sec_code = sec_code_reg[ch];
            assign sif.pin_fall = pin_fall[ch];
            assign sif.pin_both = pin_both[ch];
            assign sif.tima     = timer_a_irq;
            assign sif.timb     = timer_b_irq;
            assign sif.utx      = uart_tx_irq;
            assign sif.urx      = urx_sel;
            assign sif.adc      = analog_converter_0_irq;
            assign sif.iio      = iio_irq;
            assign sif.sec_hw   = sec_src_irq[ch];
            assign hw_req[ch]   = sif.hw_req;

            dmars_chan_sel #(.CH(ch)) u_sel (
                .sif (sif)
            );
        end
    endgenerate

    // previous pin levels for edge detection, first sample after reset only primes
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev_reg <= 4'h0;
            pin_live_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pins;
            pin_live_reg <= 1'b1;
        end
    end

    // primary and secondary select codes
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N_CH; i++) begin
                pri_code_reg[i] <= CODE_RST;
                sec_code_reg[i] <= CODE_RST;
            end
        end else begin
            for (int i = 0; i < N_CH; i++) begin
                if (pri_wr[i]) begin
                    pri_code_reg[i] <= wb_dat_i[CODE_MSB:CODE_LSB];
                end
                if (sec_wr[i]) begin
                    sec_code_reg[i] <= wb_dat_i[CODE_MSB:CODE_LSB];
                end
            end
        end
    end

    // request outputs: no interrupt enable and no pending flag takes part here
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_req_reg <= 4'h0;
        end else begin
            dma_req_reg <= hw_req | sw_trig;
        end
    end

    // sticky record of issued requests, cleared by writing one, a new request wins
    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg <= STATUS_RST;
        end else if (wr_fire && wb_adr_i == STATUS_OFS) begin
            status_reg <= (status_reg & ~wb_dat_i[3:0]) | dma_req_reg;
        end else begin
            status_reg <= status_reg | dma_req_reg;
        end
    end

    // read data mux, unmapped addresses read as zero
    always_comb begin
        logic [3:0] ph;
        logic [3:0] sh;
        ph = group_hit(wb_adr_i, PRI_BASE_OFS);
        sh = group_hit(wb_adr_i, SEC_BASE_OFS);
        rdata_next = 32'h0000_0000;
        for (int i = 0; i < N_CH; i++) begin
            if (ph[i]) begin
                rdata_next = {27'h000_0000, pri_code_reg[i]};
            end else if (sh[i]) begin
                rdata_next = {27'h000_0000, sec_code_reg[i]};
            end
        end
        if (wb_adr_i == STATUS_OFS) begin
            rdata_next = {28'h000_0000, status_reg};
        end
    end

    // single-wait acknowledge, every address answers
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req_phase;
            if (req_phase) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign dma_req  = dma_req_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !ack_reg;
    endsequence

    sequence s_ack_pulse;
        ack_reg ##1 !ack_reg;
    endsequence

    a_bus_ack_once: assert property (s_bus_req |=> s_ack_pulse)
        else $error("ack not a single pulse one cycle after request");

    // no acknowledge without a cycle on the bus
    a_ack_idle_low: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack raised with no bus cycle");

    generate
        for (genvar c = 0; c < N_CH; c++) begin : g_chk
            a_sw_trig_req: assert property (
                sw_trig[c] |=> dma_req[c] ##1 (status_reg[c] || $past(wr_fire)))
                else $error("software trigger did not raise a request");
            a_hw_req_out: assert property (
                hw_req[c] |=> dma_req[c])
                else $error("hardware request not forwarded");
            a_no_cause_quiet: assert property (
                !hw_req[c] && !sw_trig[c] |=> !dma_req[c])
                else $error("request raised without a cause");
            a_sec_handover: assert property (
                pri_code_reg[c] == CODE_SECONDARY && sec_code_reg[c] != CODE_SECONDARY
                && sec_src_irq[c] |=> dma_req[c])
                else $error("secondary source not used for code zero");
            a_pin_fall_sel: assert property (
                pri_code_reg[c] == CODE_PIN_FALL && pin_live_reg && $fell(pins[c])
                |=> dma_req[c])
                else $error("pin falling edge missed");
            a_timer_a_sel: assert property (
                pri_code_reg[c] == CODE_TA_FIRST && timer_a_irq[0] |-> hw_req[c])
                else $error("timer A 0 not selected");
            a_timer_b_sel: assert property (
                pri_code_reg[c] == CODE_TB_LAST && timer_b_irq[5] |-> hw_req[c])
                else $error("timer B 5 not selected");
            a_adc_sel: assert property (
                pri_code_reg[c] == CODE_ADC |-> hw_req[c] == analog_converter_0_irq)
                else $error("converter request not selected");
            a_reserved_mute: assert property (
                dmars_class(pri_code_reg[c]) == CLS_NONE |-> !hw_req[c])
                else $error("reserved code produced a request");
            // further code points: other ends of the timer and pin classes, serial ports, first iio code, secondary zero
            a_timer_a_last: assert property (
                pri_code_reg[c] == CODE_TA_LAST |-> hw_req[c] == timer_a_irq[4])
                else $error("timer A 4 not selected");
            a_timer_b_first: assert property (
                pri_code_reg[c] == CODE_TB_FIRST |-> hw_req[c] == timer_b_irq[0])
                else $error("timer B 0 not selected");
            a_pin_both_sel: assert property (
                pri_code_reg[c] == CODE_PIN_BOTH && pin_live_reg && $changed(pins[c])
                |=> dma_req[c])
                else $error("pin edge missed in both-edge mode");
            a_uart_tx_sel: assert property (
                pri_code_reg[c] == CODE_UART_FIRST |-> hw_req[c] == uart_tx_irq[0])
                else $error("serial port 0 transmit not selected");
            a_uart_rx_sel: assert property (
                pri_code_reg[c] == CODE_UART_LAST
                |-> hw_req[c] == (uart_ack_mode[2] ? uart_ack_irq[2] : uart_rx_irq[2]))
                else $error("serial port 2 receive or acknowledge not selected");
            a_iio_first_sel: assert property (
                pri_code_reg[c] == CODE_IIO_FIRST |-> hw_req[c] == iio_irq[IIO_BASE[c][3:0]])
                else $error("first iio code picks the wrong request");
            a_sec_zero_mute: assert property (
                pri_code_reg[c] == CODE_SECONDARY && sec_code_reg[c] == CODE_SECONDARY
                |-> !hw_req[c])
                else $error("secondary code zero produced a hardware request");
            // register writes land on the acknowledged edge, issued requests are recorded
            a_pri_write: assert property (
                pri_wr[c] |=> pri_code_reg[c] == $past(wb_dat_i[CODE_MSB:CODE_LSB]))
                else $error("primary code write did not land");
            a_sec_write: assert property (
                sec_wr[c] |=> sec_code_reg[c] == $past(wb_dat_i[CODE_MSB:CODE_LSB]))
                else $error("secondary code write did not land");
            a_status_set: assert property (
                dma_req_reg[c] |=> status_reg[c])
                else $error("issued request not recorded in status");
        end
    endgenerate

    a_iio_ch3_wrap: assert property (
        pri_code_reg[3] == 5'h1C |-> hw_req[3] == iio_irq[0])
        else $error("channel 3 iio rotation wrong");

    a_status_sticky: assert property (
        status_reg != 4'h0 && !wr_fire |=> status_reg != 4'h0)
        else $error("status flag lost without a clear");

endmodule // dmars_top

// *** dmars_src_model.sv ***
// dmars_src_model: peripheral request lines and external pins seen by the selector
// assumes the bench moves its controls just after a rising clock edge
`timescale 1ns/1ps
module dmars_src_model (
    input  wire logic [5:0]  fire_idx,
    input  wire logic        fire_en,
    input  wire logic        fire_all,
    input  wire logic [3:0]  pin_lvl,
    output logic      [3:0]  pins,
    output logic      [4:0]  timer_a_irq,
    output logic      [5:0]  timer_b_irq,
    output logic      [2:0]  uart_tx_irq,
    output logic      [2:0]  uart_rx_irq,
    output logic      [2:0]  uart_ack_irq,
    output logic             adc_irq,
    output logic      [11:0] iio_irq,
    output logic      [3:0]  sec_irq
);
    logic [36:0] lines;
    // one line high, or every line high to probe a code that must stay deaf
    always_comb begin
        lines = '0;
        if (fire_all) begin
            lines = '1;
        end else if (fire_en) begin
            lines[fire_idx] = 1'b1;
        end
    end
    // flat line index onto each peripheral, in table order
    assign timer_a_irq  = lines[4:0];
    assign timer_b_irq  = lines[10:5];
    assign uart_tx_irq  = lines[13:11];
    assign uart_rx_irq  = lines[16:14];
    assign uart_ack_irq = lines[19:17];
    assign adc_irq      = lines[20];
    assign iio_irq      = lines[32:21];
    assign sec_irq      = lines[36:33];
    assign pins         = pin_lvl;
endmodule // dmars_src_model

// *** dmars_top_tb_top.sv ***
// dmars_top_tb_top: self-checking bench for the dma request selector
// assumes dmars_top answers wishbone with one wait cycle and registers dma_req
`timescale 1ns/1ps
module dmars_top_tb_top import dmars_pkg::*;;
    logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, dma_req, pins, sec_irq, pin_lvl;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [4:0]  ta;
    logic [5:0]  tb, fire_idx;
    logic [2:0]  utx, urx, uack, uart_ack_mode;
    logic [11:0] iio;
    logic        adc, fire_en, fire_all;
    int          miscompares = 0;
    int          checks_done = 0;

    dmars_src_model SRC (.fire_idx(fire_idx), .fire_en(fire_en), .fire_all(fire_all),
        .pin_lvl(pin_lvl), .pins(pins), .timer_a_irq(ta), .timer_b_irq(tb),
        .uart_tx_irq(utx), .uart_rx_irq(urx), .uart_ack_irq(uack), .adc_irq(adc),
        .iio_irq(iio), .sec_irq(sec_irq));
    dmars_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin_0(pins[0]),
        .ext_irq_pin_1(pins[1]), .ext_irq_pin_2(pins[2]), .ext_irq_pin_3(pins[3]),
        .timer_a_irq(ta), .timer_b_irq(tb), .uart_tx_irq(utx), .uart_rx_irq(urx),
        .uart_ack_irq(uack), .uart_ack_mode(uart_ack_mode), .analog_converter_0_irq(adc),
        .iio_irq(iio), .sec_src_irq(sec_irq), .dma_req(dma_req));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        // wait for ack however long it takes, only the watchdog ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        chk(32'(n), 32'h2); // ack one wait cycle after the request is taken
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, adr, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, adr, 32'h0, r);
        chk(r, exp);
    endtask

    // hold one source (or all) and look at the request one cycle after it lands
    task automatic fire_chk(input logic [5:0] idx, input logic all, input logic [3:0] exp);
        fire_idx <= idx;
        fire_en  <= 1'b1;
        fire_all <= all;
        repeat (2) @(posedge clk);
        chk({28'h0, dma_req}, {28'h0, exp});
        fire_en  <= 1'b0;
        fire_all <= 1'b0;
        repeat (2) @(posedge clk);
        chk({28'h0, dma_req}, 32'h0);
    endtask

    // line index that a primary code must pick, -1 for reserved codes
    function automatic int exp_src(input int ch, input int code, input logic mode);
        int iio_base [4] = '{0, 7, 2, 9};
        if (code >= 3 && code <= 13) return code - 3;
        if (code >= 14 && code <= 19) begin
            if (code % 2 == 0) return 11 + (code - 14) / 2;
            return (mode ? 17 : 14) + (code - 15) / 2;
        end
        if (code == 24) return 20;
        if (code >= 25) return 21 + (iio_base[ch] + code - 25) % 12;
        return -1;
    endfunction

    task automatic test_reset();
        for (int i = 0; i < 4; i++) begin
            rd_chk(PRI_BASE_OFS + 8'(4 * i), 32'h0);
            rd_chk(SEC_BASE_OFS + 8'(4 * i), 32'h0);
        end
        rd_chk(STATUS_OFS, 32'h0);
        wr(8'h30, 32'hFFFFFFFF);
        rd_chk(8'h30, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_sw();
        for (int ch = 0; ch < 4; ch++) begin
            wr(SEC_BASE_OFS + 8'(4 * ch), 32'h20);
            @(posedge clk);
            chk({28'h0, dma_req}, 32'(1 << ch));
            @(posedge clk);
            chk({28'h0, dma_req}, 32'h0);
            rd_chk(SEC_BASE_OFS + 8'(4 * ch), 32'h0);
            rd_chk(STATUS_OFS, 32'(1 << ch));
            wr(STATUS_OFS, 32'(1 << ch));
        end
        rd_chk(STATUS_OFS, 32'h0);
        $display("test software trigger done");
    endtask

    task automatic test_secondary();
        for (int ch = 0; ch < 4; ch++) begin
            fire_chk(6'(33 + ch), 1'b0, 4'h0);
            wr(SEC_BASE_OFS + 8'(4 * ch), 32'h1);
            fire_chk(6'(33 + ch), 1'b0, 4'(1 << ch));
            fire_chk(6'h0, 1'b0, 4'h0);
            rd_chk(SEC_BASE_OFS + 8'(4 * ch), 32'h1);
            wr(SEC_BASE_OFS + 8'(4 * ch), 32'h0);
        end
        $display("test secondary done");
    endtask

    task automatic test_codes(input logic mode);
        int src;
        uart_ack_mode <= {3{mode}};
        for (int ch = 0; ch < 4; ch++) begin
            for (int code = 3; code < 32; code++) begin
                src = exp_src(ch, code, mode);
                wr(PRI_BASE_OFS + 8'(4 * ch), 32'(code));
                if (src < 0) begin
                    fire_chk(6'h0, 1'b1, 4'h0);
                end else begin
                    fire_chk(6'(src), 1'b0, 4'(1 << ch));
                end
            end
            wr(PRI_BASE_OFS + 8'(4 * ch), 32'h0);
        end
        $display("test codes mode %0d done", mode);
    endtask

    // move the pins, then count request cycles per channel over four cycles
    task automatic pin_step(input logic [3:0] lvl, input logic [3:0] exp);
        logic [3:0] seen;
        logic [3:0] twice;
        seen = 4'h0;
        twice = 4'h0;
        pin_lvl <= lvl;
        repeat (4) begin
            @(posedge clk);
            twice = twice | (seen & dma_req);
            seen = seen | dma_req;
        end
        chk({24'h0, twice, seen}, {28'h0, exp});
    endtask

    task automatic test_pins();
        for (int code = 1; code < 3; code++) begin
            for (int ch = 0; ch < 4; ch++) begin
                wr(PRI_BASE_OFS + 8'(4 * ch), 32'(code));
            end
            pin_step(4'hF, code == 2 ? 4'hF : 4'h0);
            for (int n = 0; n < 4; n++) begin
                pin_step(4'hF ^ 4'(1 << n), 4'(1 << n));
                pin_step(4'hF, code == 2 ? 4'(1 << n) : 4'h0);
            end
            pin_step(4'h0, code == 2 ? 4'hF : 4'hF);
        end
        $display("test pins done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, fire_en, fire_all} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        fire_idx = 6'h00;
        pin_lvl = 4'h0;
        uart_ack_mode = 3'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_sw();
        test_secondary();
        test_codes(1'b0);
        test_codes(1'b1);
        test_pins();
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule // dmars_top_tb_top
